// ---- src/hmfm_consts.svh ----
// offsets, field positions, reset values and vector for the halfword multiply / flag move slice
// Notes on behaviour
// - high multiply uses both upper halfwords, 32-bit product
// - low multiply uses both lower halfwords, 32-bit product
// - signed forms multiply two's-complement halfwords
// - unsigned forms multiply unsigned halfwords
// - record forms update first flag field
// - plain forms leave all flag fields alone
// - multiplies never touch the exception register
// - floating opcodes trap, vector 0x0700
// - exception bits 0:3 copied to selected field
// - exception bits 0:3 cleared after that copy
// - flag read returns whole flag register
// - masked flag write loads selected fields only
// - mask msb selects field 0, lsb field 7
// - mask one loads field, zero keeps it
`ifndef HMFM_CONSTS_SVH
`define HMFM_CONSTS_SVH
`define HMFM_ADDR_W 8
`define HMFM_REG_FLAG 8'h00
`define HMFM_REG_EXC 8'h04
`define HMFM_REG_IRQ_STATUS 8'h08
`define HMFM_REG_IRQ_MASK 8'h0C
`define HMFM_REG_LAST_RESULT 8'h10
`define HMFM_REG_TRAP_VECTOR 8'h14
`define HMFM_FLAG_RESET 32'h0000_0000
`define HMFM_EXC_RESET 32'h0000_0000
`define HMFM_MASK_RESET 3'h0
`define HMFM_PROG_VECTOR 32'h0000_0700
`define HMFM_EXC_SUMMARY_BIT 31
`define HMFM_EVT_TRAP 0
`define HMFM_EVT_RECORD 1
`define HMFM_EVT_EXC_MOVE 2
`define HMFM_EVT_W 3
`define HMFM_RESP_OKAY 2'h0
`define HMFM_RESP_SLVERR 2'h2
`endif

// ---- src/hmfm_pkg.sv ----
// operation codes for the halfword multiply / flag move slice
package hmfm_pkg;
	typedef enum logic [3:0] {
		HMFM_OP_NONE,
		HMFM_OP_MUL_HH_S,
		HMFM_OP_MUL_HH_U,
		HMFM_OP_MUL_LL_S,
		HMFM_OP_MUL_LL_U,
		HMFM_OP_EXC_TO_FLAG,
		HMFM_OP_READ_FLAG,
		HMFM_OP_WRITE_FLAG,
		HMFM_OP_FLOAT
	} hmfm_op_t;
endpackage

// ---- src/hmfm_core.sv ----
// execute slice: halfword multiplies, flag register moves, floating trap, axi4-lite view
`timescale 1ns/1ps
`include "hmfm_consts.svh"
module hmfm_core
	import hmfm_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic op_valid,
	input wire hmfm_op_t op_code,
	input wire logic op_record,
	input wire logic [31:0] src_a_gpr,
	input wire logic [31:0] src_b_gpr,
	input wire logic [2:0] target_flag_field_sel,
	input wire logic [7:0] flag_field_mask,
	output logic wb_valid,
	output logic [31:0] wb_data,
	output logic trap_req,
	output logic [31:0] trap_vector,
	output logic [31:0] condition_flag_reg,
	output logic [31:0] fixed_point_exception_reg,
	output logic irq,
	input wire logic [`HMFM_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`HMFM_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	logic [31:0] prod_hh_s;
	logic [31:0] prod_hh_u;
	logic [31:0] prod_ll_s;
	logic [31:0] prod_ll_u;
	logic [31:0] mul_result;
	logic is_mul;
	logic [3:0] rec_field;
	logic [31:0] merged_masked;
	logic [31:0] merged_exc;
	logic [31:0] next_flag;
	logic [31:0] next_exc;
	logic wr_go;
	logic [`HMFM_ADDR_W-1:0] wr_addr;
	logic flag_sw_wr;
	logic exc_sw_wr;
	logic [31:0] last_result;
	logic [`HMFM_EVT_W-1:0] irq_status;
	logic [`HMFM_EVT_W-1:0] irq_mask;
	logic [`HMFM_EVT_W-1:0] evt;
	logic [`HMFM_EVT_W-1:0] next_irq_status;

	function automatic logic [31:0] apply_strb(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// bit 0 of the architecture is the msb here, so halfword 0:15 is [31:16]
	assign prod_hh_s = $signed(src_a_gpr[31:16]) * $signed(src_b_gpr[31:16]);
	assign prod_hh_u = src_a_gpr[31:16] * src_b_gpr[31:16];
	assign prod_ll_s = $signed(src_a_gpr[15:0]) * $signed(src_b_gpr[15:0]);
	assign prod_ll_u = src_a_gpr[15:0] * src_b_gpr[15:0];

	always_comb begin
		is_mul = 1'b1;
		case (op_code)
			HMFM_OP_MUL_HH_S: mul_result = prod_hh_s;
			HMFM_OP_MUL_HH_U: mul_result = prod_hh_u;
			HMFM_OP_MUL_LL_S: mul_result = prod_ll_s;
			HMFM_OP_MUL_LL_U: mul_result = prod_ll_u;
			default: begin
				mul_result = 32'h0000_0000;
				is_mul = 1'b0;
			end
		endcase
	end

	// compare against zero is always signed, even for the unsigned products
	assign rec_field = {mul_result[31], ~mul_result[31] & (mul_result != 32'h0000_0000),
		mul_result == 32'h0000_0000,
		fixed_point_exception_reg[`HMFM_EXC_SUMMARY_BIT]};

	// field f sits at bits [31-4f -: 4]; mask bit 7-f selects it
	genvar f;
	generate
		for (f = 0; f < 8; f++) begin : g_field
			assign merged_masked[31-4*f -: 4] = flag_field_mask[7-f] ?
				src_a_gpr[31-4*f -: 4] : condition_flag_reg[31-4*f -: 4];
			assign merged_exc[31-4*f -: 4] = (target_flag_field_sel == 3'(f)) ?
				fixed_point_exception_reg[31:28] : condition_flag_reg[31-4*f -: 4];
		end
	endgenerate

	assign wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
	assign wr_addr = {s_axi_awaddr[`HMFM_ADDR_W-1:2], 2'b00};
	assign flag_sw_wr = wr_go & (wr_addr == `HMFM_REG_FLAG);
	assign exc_sw_wr = wr_go & (wr_addr == `HMFM_REG_EXC);

	// an instruction in flight wins over a software write in the same cycle
	always_comb begin
		next_flag = condition_flag_reg;
		if (op_valid && is_mul && op_record) begin
			next_flag = {rec_field, condition_flag_reg[27:0]};
		end else if (op_valid && op_code == HMFM_OP_EXC_TO_FLAG) begin
			next_flag = merged_exc;
		end else if (op_valid && op_code == HMFM_OP_WRITE_FLAG) begin
			next_flag = merged_masked;
		end else if (flag_sw_wr) begin
			next_flag = apply_strb(condition_flag_reg, s_axi_wdata, s_axi_wstrb);
		end
	end

	always_comb begin
		next_exc = fixed_point_exception_reg;
		if (op_valid && op_code == HMFM_OP_EXC_TO_FLAG) begin
			next_exc = {4'h0, fixed_point_exception_reg[27:0]};
		end else if (exc_sw_wr) begin
			next_exc = apply_strb(fixed_point_exception_reg, s_axi_wdata, s_axi_wstrb);
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			condition_flag_reg <= `HMFM_FLAG_RESET;
		end else begin
			condition_flag_reg <= next_flag;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			fixed_point_exception_reg <= `HMFM_EXC_RESET;
		end else begin
			fixed_point_exception_reg <= next_exc;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			wb_valid <= 1'b0;
			wb_data <= 32'h0000_0000;
			last_result <= 32'h0000_0000;
		end else begin
			wb_valid <= op_valid & (is_mul | (op_code == HMFM_OP_READ_FLAG));
			if (op_valid && is_mul) begin
				wb_data <= mul_result;
				last_result <= mul_result;
			end else if (op_valid && op_code == HMFM_OP_READ_FLAG) begin
				wb_data <= condition_flag_reg;
				last_result <= condition_flag_reg;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			trap_req <= 1'b0;
			trap_vector <= 32'h0000_0000;
		end else begin
			trap_req <= op_valid & (op_code == HMFM_OP_FLOAT);
			if (op_valid && op_code == HMFM_OP_FLOAT) begin
				trap_vector <= `HMFM_PROG_VECTOR;
			end
		end
	end

	// interrupt status: set beats a write-one-to-clear in the same cycle
	assign evt[`HMFM_EVT_TRAP] = op_valid & (op_code == HMFM_OP_FLOAT);
	assign evt[`HMFM_EVT_RECORD] = op_valid & is_mul & op_record;
	assign evt[`HMFM_EVT_EXC_MOVE] = op_valid & (op_code == HMFM_OP_EXC_TO_FLAG);

	always_comb begin
		next_irq_status = irq_status;
		if (wr_go && wr_addr == `HMFM_REG_IRQ_STATUS && s_axi_wstrb[0]) begin
			next_irq_status = irq_status & ~s_axi_wdata[`HMFM_EVT_W-1:0];
		end
		next_irq_status = next_irq_status | evt;
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			irq_status <= '0;
			irq_mask <= `HMFM_MASK_RESET;
		end else begin
			irq_status <= next_irq_status;
			if (wr_go && wr_addr == `HMFM_REG_IRQ_MASK && s_axi_wstrb[0]) begin
				irq_mask <= s_axi_wdata[`HMFM_EVT_W-1:0];
			end
		end
	end

	assign irq = |(irq_status & irq_mask);

	// address and data are only taken together, so no skid storage is needed
	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;
	assign s_axi_arready = ~s_axi_rvalid;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `HMFM_RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			case (wr_addr)
				`HMFM_REG_FLAG, `HMFM_REG_EXC, `HMFM_REG_IRQ_STATUS,
				`HMFM_REG_IRQ_MASK, `HMFM_REG_LAST_RESULT, `HMFM_REG_TRAP_VECTOR: begin
					s_axi_bresp <= `HMFM_RESP_OKAY;
				end
				default: s_axi_bresp <= `HMFM_RESP_SLVERR;
			endcase
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `HMFM_RESP_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `HMFM_RESP_OKAY;
			case ({s_axi_araddr[`HMFM_ADDR_W-1:2], 2'b00})
				`HMFM_REG_FLAG: s_axi_rdata <= condition_flag_reg;
				`HMFM_REG_EXC: s_axi_rdata <= fixed_point_exception_reg;
				`HMFM_REG_IRQ_STATUS: s_axi_rdata <= {29'h0000_0000, irq_status};
				`HMFM_REG_IRQ_MASK: s_axi_rdata <= {29'h0000_0000, irq_mask};
				`HMFM_REG_LAST_RESULT: s_axi_rdata <= last_result;
				`HMFM_REG_TRAP_VECTOR: s_axi_rdata <= `HMFM_PROG_VECTOR;
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `HMFM_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	chk_hh_signed_product: assert property (
		op_valid && op_code == HMFM_OP_MUL_HH_S |=> wb_valid &&
		$signed(wb_data) == $signed($past(src_a_gpr[31:16])) * $signed($past(src_b_gpr[31:16])))
		else $error("high signed product wrong");

	chk_ll_unsigned_product: assert property (
		op_valid && op_code == HMFM_OP_MUL_LL_U |=> wb_valid &&
		wb_data == 32'($past(src_a_gpr[15:0])) * 32'($past(src_b_gpr[15:0])))
		else $error("low unsigned product wrong");

	chk_signed_negative: assert property (
		op_valid && op_code == HMFM_OP_MUL_LL_S && src_a_gpr[15] && !src_b_gpr[15]
		&& src_b_gpr[15:0] != 16'h0000 && src_a_gpr[15:0] != 16'h0000 |=> wb_data[31])
		else $error("signed product lost its sign");

	chk_unsigned_hh: assert property (
		op_valid && op_code == HMFM_OP_MUL_HH_U |=>
		wb_data == 32'($past(src_a_gpr[31:16])) * 32'($past(src_b_gpr[31:16])))
		else $error("high unsigned product wrong");

	chk_record_field: assert property (
		op_valid && is_mul && op_record |=> condition_flag_reg[31:28] ==
		{wb_data[31], !wb_data[31] && wb_data != 32'h0000_0000, wb_data == 32'h0000_0000,
		$past(fixed_point_exception_reg[31])} && condition_flag_reg[27:0] ==
		$past(condition_flag_reg[27:0]))
		else $error("record field not set from product");

	chk_plain_flags_kept: assert property (
		op_valid && is_mul && !op_record && !flag_sw_wr |=> $stable(condition_flag_reg))
		else $error("plain multiply changed flags");

	chk_mul_exc_kept: assert property (
		op_valid && is_mul && !exc_sw_wr |=> $stable(fixed_point_exception_reg))
		else $error("multiply changed exception register");

	chk_float_trap: assert property (
		op_valid && op_code == HMFM_OP_FLOAT |=> trap_req && trap_vector == 32'h0000_0700
		##1 !trap_req || $past(op_valid && op_code == HMFM_OP_FLOAT))
		else $error("floating opcode did not trap");

	chk_exc_copy_clear: assert property (
		op_valid && op_code == HMFM_OP_EXC_TO_FLAG |=>
		condition_flag_reg[31-4*$past(target_flag_field_sel) -: 4] ==
		$past(fixed_point_exception_reg[31:28]) && fixed_point_exception_reg[31:28] == 4'h0)
		else $error("exception move wrong");

	chk_read_flags: assert property (
		op_valid && op_code == HMFM_OP_READ_FLAG |=> wb_valid &&
		wb_data == $past(condition_flag_reg))
		else $error("flag read wrong");

	chk_masked_write: assert property (
		op_valid && op_code == HMFM_OP_WRITE_FLAG |=> condition_flag_reg ==
		(($past(src_a_gpr) & $past({{4{flag_field_mask[7]}}, {4{flag_field_mask[6]}},
		{4{flag_field_mask[5]}}, {4{flag_field_mask[4]}}, {4{flag_field_mask[3]}},
		{4{flag_field_mask[2]}}, {4{flag_field_mask[1]}}, {4{flag_field_mask[0]}}}))
		| ($past(condition_flag_reg) & ~$past({{4{flag_field_mask[7]}},
		{4{flag_field_mask[6]}}, {4{flag_field_mask[5]}}, {4{flag_field_mask[4]}},
		{4{flag_field_mask[3]}}, {4{flag_field_mask[2]}}, {4{flag_field_mask[1]}},
		{4{flag_field_mask[0]}}}))))
		else $error("masked flag write wrong");

	chk_trap_status_set: assert property (
		op_valid && op_code == HMFM_OP_FLOAT |=> irq_status[`HMFM_EVT_TRAP])
		else $error("trap did not set its status bit");

	chk_record_status_set: assert property (
		op_valid && is_mul && op_record |=> irq_status[`HMFM_EVT_RECORD])
		else $error("record multiply did not set its status bit");

	chk_move_status_set: assert property (
		op_valid && op_code == HMFM_OP_EXC_TO_FLAG |=> irq_status[`HMFM_EVT_EXC_MOVE])
		else $error("exception move did not set its status bit");

	chk_float_flags_kept: assert property (
		op_valid && op_code == HMFM_OP_FLOAT && !flag_sw_wr && !exc_sw_wr |=>
		$stable(condition_flag_reg) && $stable(fixed_point_exception_reg))
		else $error("floating opcode changed flags");

	chk_write_resp_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before taken");

	chk_read_data_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before taken");
endmodule

// ---- tb/tb.sv ----
// self-checking bench for the halfword multiply / flag move slice
`timescale 1ns/1ps
`include "hmfm_consts.svh"
module tb
	import hmfm_pkg::*;
;
logic sys_clk = 1'b0;
logic nrst = 1'b0;
logic op_valid = 1'b0;
hmfm_op_t op_code = HMFM_OP_NONE;
logic op_record = 1'b0;
logic [31:0] src_a_gpr = 32'h0000_0000;
logic [31:0] src_b_gpr = 32'h0000_0000;
logic [2:0] target_flag_field_sel = 3'h0;
logic [7:0] flag_field_mask = 8'h00;
logic wb_valid, trap_req, irq;
logic [31:0] wb_data, trap_vector, condition_flag_reg, fixed_point_exception_reg;
logic [7:0] s_axi_awaddr = 8'h00;
logic [7:0] s_axi_araddr = 8'h00;
logic s_axi_awvalid = 1'b0;
logic s_axi_wvalid = 1'b0;
logic s_axi_bready = 1'b0;
logic s_axi_arvalid = 1'b0;
logic s_axi_rready = 1'b0;
logic [31:0] s_axi_wdata = 32'h0000_0000;
logic [3:0] s_axi_wstrb = 4'h0;
logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
logic [1:0] s_axi_bresp, s_axi_rresp, rs;
logic [31:0] s_axi_rdata, rd, fl, ex, p, a, b;
int errors = 0;
int comparisons = 0;
int cycles = 0;
hmfm_op_t mul_ops [4] = '{HMFM_OP_MUL_HH_S, HMFM_OP_MUL_HH_U, HMFM_OP_MUL_LL_S, HMFM_OP_MUL_LL_U};

hmfm_core u_dut (.sys_clk(sys_clk), .nrst(nrst), .op_valid(op_valid), .op_code(op_code),
	.op_record(op_record), .src_a_gpr(src_a_gpr), .src_b_gpr(src_b_gpr),
	.target_flag_field_sel(target_flag_field_sel), .flag_field_mask(flag_field_mask),
	.wb_valid(wb_valid), .wb_data(wb_data), .trap_req(trap_req), .trap_vector(trap_vector),
	.condition_flag_reg(condition_flag_reg),
	.fixed_point_exception_reg(fixed_point_exception_reg), .irq(irq),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

always #10 sys_clk = ~sys_clk;

task final_report;
	if (errors == 0 && comparisons > 0) begin
		$display("Finished cleanly");
	end else begin
		$display("Finished with errors");
	end
	$finish;
endtask

// a hung handshake would otherwise stall the run forever
always @(posedge sys_clk) begin
	cycles++;
	if (cycles > 2000) begin
		errors++;
		final_report();
	end
end

task chk(input logic [31:0] got, input logic [31:0] exp);
	comparisons++;
	if (got !== exp) begin
		errors++;
		$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
	end
endtask

task axi_wr(input logic [7:0] ad, input logic [31:0] d, output logic [1:0] r);
	@(posedge sys_clk);
	s_axi_awaddr <= ad;
	s_axi_wdata <= d;
	s_axi_wstrb <= 4'hf;
	s_axi_awvalid <= 1'b1;
	s_axi_wvalid <= 1'b1;
	do @(posedge sys_clk); while ((s_axi_awready & s_axi_wready) !== 1'b1);
	s_axi_awvalid <= 1'b0;
	s_axi_wvalid <= 1'b0;
	s_axi_bready <= 1'b1;
	do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
	r = s_axi_bresp;
	s_axi_bready <= 1'b0;
endtask

task axi_rd(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] r);
	@(posedge sys_clk);
	s_axi_araddr <= ad;
	s_axi_arvalid <= 1'b1;
	do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
	s_axi_arvalid <= 1'b0;
	s_axi_rready <= 1'b1;
	do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
	d = s_axi_rdata;
	r = s_axi_rresp;
	s_axi_rready <= 1'b0;
endtask

// outputs are sampled just after the edge that answers the op
task do_op(input hmfm_op_t c, input logic r, input logic [31:0] sa, input logic [31:0] sb);
	@(posedge sys_clk);
	op_valid <= 1'b1;
	op_code <= c;
	op_record <= r;
	src_a_gpr <= sa;
	src_b_gpr <= sb;
	@(posedge sys_clk);
	op_valid <= 1'b0;
	#1;
endtask

initial begin
	repeat (3) @(posedge sys_clk);
	nrst <= 1'b1;
	axi_rd(`HMFM_REG_FLAG, rd, rs);
	chk(rd, `HMFM_FLAG_RESET);
	chk({30'h0, rs}, {30'h0, `HMFM_RESP_OKAY});
	axi_rd(`HMFM_REG_EXC, rd, rs);
	chk(rd, `HMFM_EXC_RESET);
	ex = 32'hA000_0000;
	fl = 32'h1234_5678;
	axi_wr(`HMFM_REG_EXC, ex, rs);
	chk({30'h0, rs}, {30'h0, `HMFM_RESP_OKAY});
	axi_wr(`HMFM_REG_FLAG, fl, rs);
	for (int i = 0; i < 8; i++) begin
		a = i[2] ? 32'h0000_0000 : 32'h8003_8001;
		b = 32'hFFFE_0002;
		case (i[1:0])
			2'd0: p = $signed(a[31:16]) * $signed(b[31:16]);
			2'd1: p = {16'h0000, a[31:16]} * {16'h0000, b[31:16]};
			2'd2: p = $signed(a[15:0]) * $signed(b[15:0]);
			default: p = {16'h0000, a[15:0]} * {16'h0000, b[15:0]};
		endcase
		if (i[0] ^ i[2]) begin
			fl[31:28] = {p[31], !p[31] && p != 0, p == 0, ex[31]};
		end
		do_op(mul_ops[i[1:0]], i[0] ^ i[2], a, b);
		chk({31'h0, wb_valid}, 32'h1);
		chk(wb_data, p);
		chk(condition_flag_reg, fl);
		chk(fixed_point_exception_reg, ex);
	end
	@(posedge sys_clk);
	target_flag_field_sel <= 3'd5;
	fl[11:8] = ex[31:28];
	ex[31:28] = 4'h0;
	do_op(HMFM_OP_EXC_TO_FLAG, 1'b0, 32'h0000_0000, 32'h0000_0000);
	chk(condition_flag_reg, fl);
	chk(fixed_point_exception_reg, ex);
	do_op(HMFM_OP_READ_FLAG, 1'b0, 32'h0000_0000, 32'h0000_0000);
	chk(wb_data, fl);
	axi_rd(`HMFM_REG_LAST_RESULT, rd, rs);
	chk(rd, fl);
	@(posedge sys_clk);
	flag_field_mask <= 8'b0110_0100;
	a = 32'hFEDC_BA98;
	for (int f = 0; f < 8; f++) begin
		if (f == 1 || f == 2 || f == 5) begin
			fl[31-4*f -: 4] = a[31-4*f -: 4];
		end
	end
	do_op(HMFM_OP_WRITE_FLAG, 1'b0, a, 32'h0000_0000);
	chk(condition_flag_reg, fl);
	do_op(HMFM_OP_FLOAT, 1'b0, 32'h0000_0000, 32'h0000_0000);
	chk({31'h0, trap_req}, 32'h1);
	chk(trap_vector, `HMFM_PROG_VECTOR);
	@(posedge sys_clk);
	#1;
	chk({31'h0, trap_req}, 32'h0);
	// every event has fired by now, so all three status bits stand
	chk({31'h0, irq}, 32'h0);
	axi_rd(`HMFM_REG_IRQ_STATUS, rd, rs);
	chk(rd, 32'h0000_0007);
	axi_wr(`HMFM_REG_IRQ_MASK, 32'h0000_0001, rs);
	#1;
	chk({31'h0, irq}, 32'h1);
	axi_rd(`HMFM_REG_IRQ_MASK, rd, rs);
	chk(rd, 32'h0000_0001);
	axi_wr(`HMFM_REG_IRQ_STATUS, 32'h0000_0001, rs);
	#1;
	chk({31'h0, irq}, 32'h0);
	axi_rd(`HMFM_REG_IRQ_STATUS, rd, rs);
	chk(rd, 32'h0000_0006);
	axi_rd(`HMFM_REG_TRAP_VECTOR, rd, rs);
	chk(rd, `HMFM_PROG_VECTOR);
	axi_rd(8'h40, rd, rs);
	chk({30'h0, rs}, {30'h0, `HMFM_RESP_SLVERR});
	chk(rd, 32'h0000_0000);
	axi_wr(8'h40, 32'h0000_FFFF, rs);
	chk({30'h0, rs}, {30'h0, `HMFM_RESP_SLVERR});
	final_report();
end
endmodule
